// ===== hw/ftm_consts.vh
`ifndef FTM_CONSTS_VH
`define FTM_CONSTS_VH

// Register byte offsets
`define FTM_ADR_CFG      8'h00
`define FTM_ADR_CHMODE   8'h04
`define FTM_ADR_FANDIV   8'h08
`define FTM_ADR_VAL1     8'h0C
`define FTM_ADR_VAL2     8'h10
`define FTM_ADR_LIM1     8'h14
`define FTM_ADR_LIM2     8'h18
`define FTM_ADR_STAT     8'h1C
`define FTM_ADR_ICLR     8'h20
`define FTM_ADR_IEN      8'h24

// Configuration register bits
`define FTM_CFG_START    0
`define FTM_CFG_INTEN    1
`define FTM_CFG_INTCLR   3

// Channel mode bits: 0 = tach input, 1 = analog input
`define FTM_CH_PIN1      0
`define FTM_CH_PIN2      1

// Divisor fields in the shared register
`define FTM_DIV1_LSB     4
`define FTM_DIV2_LSB     6

// Event bits of status, clear and enable registers
`define FTM_EV_FAIL1     0
`define FTM_EV_FAIL2     1
`define FTM_EV_DONE1     2
`define FTM_EV_DONE2     3
`define FTM_EV_W         4

// Reset values
`define FTM_RST_CFG      8'h00
`define FTM_RST_CHMODE   2'h0
`define FTM_RST_DIV      4'h5
`define FTM_RST_LIM      8'hFF
`define FTM_RST_VAL      8'h00
`define FTM_CNT_FULL     8'hFF

// Timing: system clock and tach reference clock
`define FTM_CLK_HZ       100000000
`define FTM_REF_HZ       22500

`endif

// ===== hw/ftm_fan_tach_monitor.v
// Summary of operation
// RULE1: Channel mode bits 0 and 1 pick analog or tach use per pin.
// RULE2: Both pin select bits reset to zero, meaning tach operation.
// RULE3: Reference clock gated into 8-bit counter over two tach periods.
// RULE4: Count from a rising tach edge to the second following rising edge.
// RULE5: Monitoring starts on a config write with start one, clear zero.
// RULE6: Software should set interrupt enable when starting monitoring.
// RULE7: Enabled fans are measured one after the other with one counter.
// RULE8: Measurement ends after two tach cycles or at count 255.
// RULE9: Each result goes to its fan value register, readable any time.
// RULE10: Measurements repeat while monitoring stays started.
// RULE11: Per-fan prescaler divides reference by 1, 2, 4 or 8.
// RULE12: Each prescaler resets to divide by two.
// RULE13: Count equals ref times sixty over rpm times divisor.
// RULE14: Divisor selections live in bits 4 to 7 of shared register.
// RULE15: Failure flagged when the count is greater than the low limit.
// RULE16: No overspeed limit; fan limit registers hold low limit only.
// RULE17: Fan and analog sequences share the start event only.
// RULE18: Fan one divisor in bits 4-5, fan two in 6-7, codes 1,2,4,8.
// RULE19: Counter holds at full scale and that value is stored.
`timescale 1ns/1ps
`default_nettype none
`include "ftm_consts.vh"

module ftm_fan_tach_monitor #(
   parameter REF_DIV = `FTM_CLK_HZ / `FTM_REF_HZ
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        tach_input_one,
   input  wire        tach_input_two,
   input  wire [3:0]  core_voltage_code_low,
   output reg  [1:0]  pin_analog_sel,
   output reg         analog_start,
   output reg         irq
);

   // Sequencer states, one-hot
   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_ARM   = 4'b0010;
   localparam [3:0] S_COUNT = 4'b0100;
   localparam [3:0] S_STORE = 4'b1000;

   // Last count of the reference divider, cut to the divider width
   localparam [12:0] REF_LAST = REF_DIV[12:0] - 13'h0001;

   // Mask of prescaler bits that must be all ones for a tick
   function [2:0] div_mask;
      input [1:0] code;
      begin
         case (code)
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            default: div_mask = 3'h7;
         endcase
      end
   endfunction

   // Saturating increment, holds at full scale
   function [7:0] sat_inc;
      input [7:0] v;
      begin
         if (v == `FTM_CNT_FULL) begin
            sat_inc = v;
         end else begin
            sat_inc = v + 8'h01;
         end
      end
   endfunction

   // Offset match, shared by the per-register write strobes
   function reg_hit;
      input [7:0] adr;
      input [7:0] off;
      begin
         reg_hit = (adr == off);
      end
   endfunction

   reg  [7:0]  cfg_q;
   reg  [3:0]  div_q;
   reg  [7:0]  val1_q;
   reg  [7:0]  val2_q;
   reg  [7:0]  lim1_q;
   reg  [7:0]  lim2_q;
   reg  [3:0]  stat_q;
   reg  [3:0]  ien_q;
   reg         run_q;
   reg  [12:0] ref_cnt_q;
   reg         ref_tick_q;
   reg  [2:0]  ps_cnt_q;
   reg  [3:0]  state_q;
   reg         fan_q;
   reg  [7:0]  cnt_q;
   reg         edge2_q;
   reg         tach1_q;
   reg         tach2_q;
   reg         hist_ok_q;

   wire        wb_req;
   wire        wr;
   wire        start_wr;
   wire        stop_wr;
   wire        tach_input_one_en;
   wire        tach_input_two_en;
   wire        tach_now;
   wire        tach_prev;
   wire        tach_rise;
   wire [1:0]  div_sel;
   wire        ps_tick;
   wire        done;
   wire        fail;
   wire        next_fan;
   wire        cur_en;
   wire        wr_cfg;
   wire        wr_chmode;
   wire        wr_fandiv;
   wire        wr_lim1;
   wire        wr_lim2;
   wire        wr_iclr;
   wire        wr_ien;
   reg  [3:0]  ev_set;
   reg  [7:0]  rd_data;

   // A request is answered once; ack drops the cycle after it rose
   assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr       = wb_req & wb_we_i & wb_sel_i[0];
   assign start_wr = wr && (wb_adr_i == `FTM_ADR_CFG) &&
                     wb_dat_i[`FTM_CFG_START] &&
                     !wb_dat_i[`FTM_CFG_INTCLR];              // [RULE5]
   assign stop_wr  = wr && (wb_adr_i == `FTM_ADR_CFG) &&
                     !wb_dat_i[`FTM_CFG_START];

   // Per-register write strobes, one cycle wide at the taking edge
   assign wr_cfg    = wr & reg_hit(wb_adr_i, `FTM_ADR_CFG);
   assign wr_chmode = wr & reg_hit(wb_adr_i, `FTM_ADR_CHMODE);
   assign wr_fandiv = wr & reg_hit(wb_adr_i, `FTM_ADR_FANDIV);
   assign wr_lim1   = wr & reg_hit(wb_adr_i, `FTM_ADR_LIM1);
   assign wr_lim2   = wr & reg_hit(wb_adr_i, `FTM_ADR_LIM2);
   assign wr_iclr   = wr & reg_hit(wb_adr_i, `FTM_ADR_ICLR);
   assign wr_ien    = wr & reg_hit(wb_adr_i, `FTM_ADR_IEN);

   // A pin set to analog use takes its fan out of the sequence
   assign tach_input_one_en = ~pin_analog_sel[`FTM_CH_PIN1];           // [RULE1]
   assign tach_input_two_en = ~pin_analog_sel[`FTM_CH_PIN2];           // [RULE1]
   // A pin turned analog mid-measurement would only saturate; drop it
   assign cur_en  = fan_q ? tach_input_two_en : tach_input_one_en;               // [RULE1]

   // Single counter is steered to the fan under measurement
   assign tach_now  = fan_q ? tach_input_two : tach_input_one; // [RULE7]
   assign tach_prev = fan_q ? tach2_q : tach1_q;
   assign tach_rise = hist_ok_q & tach_now & ~tach_prev;
   assign div_sel   = fan_q ? div_q[3:2] : div_q[1:0];       // [RULE18]
   assign ps_tick   = ref_tick_q &&
                      ((ps_cnt_q & div_mask(div_sel)) ==
                       div_mask(div_sel));                    // [RULE11]

   // Second further rising edge or full scale ends the measurement
   assign done = (state_q == S_COUNT) &&
                 ((tach_rise && edge2_q) ||
                  (cnt_q == `FTM_CNT_FULL));                 // [RULE8]
   // Period grows as the fan slows, so above the limit is a failure
   assign fail = fan_q ? (cnt_q > lim2_q) : (cnt_q > lim1_q); // [RULE15]
   // Alternate when both fans are enabled, otherwise stay on one
   assign next_fan = fan_q ? ~tach_input_one_en : tach_input_two_en;             // [RULE7]

   // Reference clock divider; the count is a period, not a bound
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_q  <= 13'h0000;
         ref_tick_q <= 1'b0;
      end else if (ref_cnt_q == REF_LAST) begin
         ref_cnt_q  <= 13'h0000;
         ref_tick_q <= 1'b1;
      end else begin
         ref_cnt_q  <= ref_cnt_q + 13'h0001;
         ref_tick_q <= 1'b0;
      end
   end

   // Tach history for edge detection; no edge until one real sample
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tach1_q   <= 1'b0;
         tach2_q   <= 1'b0;
         hist_ok_q <= 1'b0;
      end else begin
         tach1_q   <= tach_input_one;
         tach2_q   <= tach_input_two;
         hist_ok_q <= 1'b1;
      end
   end

   // Run flag; analog side gets only the shared start pulse
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q        <= 1'b0;
         analog_start <= 1'b0;
      end else begin
         analog_start <= start_wr;                           // [RULE17]
         if (start_wr) begin
            run_q <= 1'b1;                                   // [RULE5]
         end else if (stop_wr) begin
            run_q <= 1'b0;
         end
      end
   end

   // Measurement sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= S_IDLE;
         fan_q    <= 1'b0;
         cnt_q    <= 8'h00;
         edge2_q  <= 1'b0;
         ps_cnt_q <= 3'h0;
         val1_q   <= `FTM_RST_VAL;
         val2_q   <= `FTM_RST_VAL;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (run_q && (tach_input_one_en || tach_input_two_en)) begin
                  fan_q   <= ~tach_input_one_en;
                  state_q <= S_ARM;
               end
            end
            S_ARM: begin
               cnt_q    <= 8'h00;
               edge2_q  <= 1'b0;
               ps_cnt_q <= 3'h0;
               if (!run_q || !cur_en) begin
                  state_q <= S_IDLE;
               end else if (tach_rise) begin
                  state_q <= S_COUNT;                        // [RULE4]
               end
            end
            S_COUNT: begin
               if (!run_q || !cur_en) begin
                  state_q <= S_IDLE;
               end else if (done) begin
                  state_q <= S_STORE;
               end else begin
                  if (tach_rise) begin
                     edge2_q <= 1'b1;                        // [RULE4]
                  end
                  if (ref_tick_q) begin
                     ps_cnt_q <= ps_cnt_q + 3'h1;
                  end
                  if (ps_tick) begin
                     cnt_q <= sat_inc(cnt_q);   // [RULE3] [RULE19]
                  end
               end
            end
            S_STORE: begin
               // Stored value is ref*60/(rpm*divisor) at two pulses/rev
               if (fan_q) begin
                  val2_q <= cnt_q;                  // [RULE9] [RULE13]
               end else begin
                  val1_q <= cnt_q;                  // [RULE9] [RULE13]
               end
               fan_q <= next_fan;
               if (run_q && (tach_input_one_en || tach_input_two_en)) begin
                  state_q <= S_ARM;                          // [RULE10]
               end else begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Events raised at each store
   always @* begin
      ev_set = 4'h0;
      if (state_q == S_STORE) begin
         ev_set[fan_q ? `FTM_EV_DONE2 : `FTM_EV_DONE1] = 1'b1;
         ev_set[fan_q ? `FTM_EV_FAIL2 : `FTM_EV_FAIL1] = fail; // [RULE15]
      end
   end

   // Software registers; set wins over a clear in the same cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q          <= `FTM_RST_CFG;
         pin_analog_sel <= `FTM_RST_CHMODE;                  // [RULE2]
         div_q          <= `FTM_RST_DIV;                     // [RULE12]
         lim1_q         <= `FTM_RST_LIM;
         lim2_q         <= `FTM_RST_LIM;
         stat_q         <= 4'h0;
         ien_q          <= 4'h0;
      end else begin
         if (wr_cfg) begin
            cfg_q <= wb_dat_i[7:0];
         end else if (wr_chmode) begin
            pin_analog_sel <= wb_dat_i[1:0];                 // [RULE1]
         end else if (wr_fandiv) begin
            div_q <= wb_dat_i[7:4];                          // [RULE14]
         end else if (wr_lim1) begin
            lim1_q <= wb_dat_i[7:0];                         // [RULE16]
         end else if (wr_lim2) begin
            lim2_q <= wb_dat_i[7:0];                         // [RULE16]
         end else if (wr_ien) begin
            ien_q <= wb_dat_i[3:0];
         end
         if (wr_iclr) begin
            stat_q <= (stat_q & ~wb_dat_i[3:0]) | ev_set;
         end else begin
            stat_q <= stat_q | ev_set;
         end
      end
   end

   // Read mux; the divisor register mirrors the voltage code pins
   always @* begin
      if (wb_adr_i == `FTM_ADR_CFG) begin
         rd_data = cfg_q;
      end else if (wb_adr_i == `FTM_ADR_CHMODE) begin
         rd_data = {6'h00, pin_analog_sel};
      end else if (wb_adr_i == `FTM_ADR_FANDIV) begin
         rd_data = {div_q, core_voltage_code_low};           // [RULE14]
      end else if (wb_adr_i == `FTM_ADR_VAL1) begin
         rd_data = val1_q;                                   // [RULE9]
      end else if (wb_adr_i == `FTM_ADR_VAL2) begin
         rd_data = val2_q;                                   // [RULE9]
      end else if (wb_adr_i == `FTM_ADR_LIM1) begin
         rd_data = lim1_q;
      end else if (wb_adr_i == `FTM_ADR_LIM2) begin
         rd_data = lim2_q;
      end else if (wb_adr_i == `FTM_ADR_STAT) begin
         rd_data = {4'h0, stat_q};
      end else if (wb_adr_i == `FTM_ADR_IEN) begin
         rd_data = {4'h0, ien_q};
      end else begin
         rd_data = 8'h00;
      end
   end

   // Bus answer one cycle after the request; unmapped reads give zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_data};
         end
      end
   end

   // Level interrupt gated by config enable and clear bits
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(stat_q & ien_q)) && cfg_q[`FTM_CFG_INTEN] &&
                !cfg_q[`FTM_CFG_INTCLR];                     // [RULE6]
      end
   end

endmodule
`default_nettype wire

// ===== tb/ftm_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_consts.vh"
module ftm_chk #(
   parameter REF_DIV = 4444
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [3:0]  core_voltage_code_low,
   input wire logic [1:0]  pin_analog_sel,
   input wire logic        analog_start,
   input wire logic        irq
);
   logic [7:0] cfg_q;
   logic [1:0] chm_q;
   wire        rd_ack = wb_ack_o && !wb_we_i;
   // Shadow of written control bits, updated at the taking edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 8'h00;
         chm_q <= 2'h0;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                   && wb_sel_i[0]) begin
         if (wb_adr_i == `FTM_ADR_CFG) cfg_q <= wb_dat_i[7:0];
         if (wb_adr_i == `FTM_ADR_CHMODE) chm_q <= wb_dat_i[1:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Start only counts when monitoring was stopped before
   sequence s_go;
      s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `FTM_ADR_CFG
                  && wb_dat_i[0] && !wb_dat_i[3] && !cfg_q[0]);
   endsequence
   property p_ack;
      s_take |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   property p_noreq;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_hold;
      $changed(wb_dat_o) |-> rd_ack;
   endproperty
   property p_cfg;
      rd_ack && wb_adr_i == `FTM_ADR_CFG
         |-> (wb_dat_o[3:0] & 4'hB) == (cfg_q[3:0] & 4'hB);
   endproperty
   property p_vid;
      rd_ack && wb_adr_i == `FTM_ADR_FANDIV
         |-> wb_dat_o[3:0] == $past(core_voltage_code_low);
   endproperty
   property p_sel;
      pin_analog_sel == chm_q;
   endproperty
   property p_go;
      s_go |-> ##[1:2] analog_start ##1 !analog_start;
   endproperty
   property p_irqoff;
      (!cfg_q[1] || cfg_q[3]) [*2] |-> !irq;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_noreq: assert property (p_noreq) else $error("ack without request");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_cfg: assert property (p_cfg) else $error("config readback");
   a_vid: assert property (p_vid) else $error("code bits");
   a_sel: assert property (p_sel) else $error("pin select");
   a_go: assert property (p_go) else $error("analog start");
   a_irqoff: assert property (p_irqoff) else $error("irq not gated");
endmodule
bind ftm_fan_tach_monitor ftm_chk #(.REF_DIV(REF_DIV)) i_ftm_chk (
   .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_voltage_code_low,
   .pin_analog_sel, .analog_start, .irq);
`default_nettype wire

// ===== tb/ftm_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// Tach outputs of two fans; fans spin freely, so edges never pause
module ftm_fan_model (
   input  wire logic        clk,
   input  wire logic [15:0] per1,
   input  wire logic [15:0] per2,
   output logic             tach1,
   output logic             tach2
);
   logic [15:0] c1 = 16'h0000;
   logic [15:0] c2 = 16'h0001;
   // Half-high square wave, two pulses per turn
   always @(posedge clk) begin
      c1 <= (c1 + 16'h0001 >= per1) ? 16'h0000 : c1 + 16'h0001;
      c2 <= (c2 + 16'h0001 >= per2) ? 16'h0000 : c2 + 16'h0001;
   end
   assign tach1 = c1 < (per1 >> 1);
   assign tach2 = c2 < (per2 >> 1);
endmodule
`default_nettype wire

// ===== tb/test_fan_tach_period_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_consts.vh"
module test_fan_tach_period_monitor;
   localparam int RD = 4; // Short reference divide keeps runs brief
   logic        clk, rst_n, cyc, stb, we, ack, irq, ast, t1, t2;
   logic [7:0]  adr, q, v;
   logic [3:0]  vid;
   logic [1:0]  psel;
   logic [31:0] di, dq;
   logic [15:0] p1, p2;
   int          num_errors, total_checks, c;
   ftm_fan_tach_monitor #(.REF_DIV(RD)) i_ftm_fan_tach_monitor (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di),
      .wb_dat_o(dq), .wb_ack_o(ack), .tach_input_one(t1),
      .tach_input_two(t2), .core_voltage_code_low(vid),
      .pin_analog_sel(psel), .analog_start(ast), .irq(irq));
   ftm_fan_model i_ftm_fan_model (.clk(clk), .per1(p1), .per2(p2),
      .tach1(t1), .tach2(t2));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input logic [7:0] g, e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One classic cycle; waits for ack, then idles a cycle
   task automatic bus(input logic w, input logic [7:0] a, d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      di <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dq[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         cmp(8'h00, 8'h01);
         summarize();
      end
   endtask
   task automatic rc(input logic [7:0] a, e);
      bus(1'b0, a, 8'h00);
      cmp(q, e);
   endtask
   // Count may be one tick off with prescaler phase
   task automatic near(input logic [7:0] a, input int e);
      logic [7:0] x;
      x = (e > 255) ? 8'hFF : e[7:0];
      bus(1'b0, a, 8'h00);
      if (q === x - 8'h01 || q === x + 8'h01) cmp(q, q);
      else cmp(q, x);
   endtask
   // Ticks over two tach periods at divide code k
   function automatic int cnt(input int per, input int k);
      return 2 * per / (RD << k);
   endfunction
   // Clear a done flag and poll for it, twice for a clean result
   task automatic wdone(input int b);
      repeat (2) begin
         c = 0;
         bus(1'b1, `FTM_ADR_ICLR, 8'h01 << b);
         do begin
            bus(1'b0, `FTM_ADR_STAT, 8'h00);
            c++;
         end while (q[b] !== 1'b1 && c < 5000);
         if (c >= 5000) begin
            cmp(8'h00, 8'h01);
            summarize();
         end
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard well past the longest expected run
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial begin
      {num_errors, total_checks} = 0;
      {rst_n, cyc, stb, we, adr, di} = 0;
      v = 8'($urandom(32'hA531));
      vid = 4'($urandom);
      p1 = 16'(RD * (40 + $urandom % 150));
      p2 = 16'(RD * (40 + $urandom % 150));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(`FTM_ADR_CFG, 8'h00);
      rc(`FTM_ADR_CHMODE, 8'h00);
      rc(`FTM_ADR_FANDIV, {4'h5, vid});
      rc(`FTM_ADR_LIM1, 8'hFF);
      rc(`FTM_ADR_IEN, 8'h00);
      bus(1'b1, `FTM_ADR_VAL2, 8'h5A);
      bus(1'b1, 8'h40, 8'h5A);
      rc(`FTM_ADR_VAL2, 8'h00);
      rc(8'h40, 8'h00);
      bus(1'b1, `FTM_ADR_LIM2, v);
      rc(`FTM_ADR_LIM2, v);
      // Both fans at default divide
      bus(1'b1, `FTM_ADR_IEN, 8'h0F);
      bus(1'b1, `FTM_ADR_CFG, 8'h03);
      wdone(3);
      near(`FTM_ADR_VAL1, cnt(p1, 1));
      near(`FTM_ADR_VAL2, cnt(p2, 1));
      // Second pin to analog; every divide code on fan one
      bus(1'b1, `FTM_ADR_CHMODE, 8'h02);
      bus(1'b0, `FTM_ADR_VAL2, 8'h00);
      v = q;
      p2 <= p2 + 16'd40;
      for (int k = 0; k < 4; k++) begin
         p1 <= 16'((30 + $urandom % 100) * (RD << k) / 2);
         bus(1'b1, `FTM_ADR_FANDIV, {2'b01, 2'(k), 4'h0});
         wdone(2);
         near(`FTM_ADR_VAL1, cnt(p1, k));
      end
      rc(`FTM_ADR_VAL2, v);
      // Slow fan saturates and trips the low limit
      bus(1'b1, `FTM_ADR_LIM1, 8'h80);
      bus(1'b1, `FTM_ADR_FANDIV, 8'h40);
      p1 <= 16'(RD * 400);
      wdone(2);
      rc(`FTM_ADR_VAL1, 8'hFF);
      rc(`FTM_ADR_ICLR, 8'h00);
      bus(1'b0, `FTM_ADR_STAT, 8'h00);
      cmp({7'h0, q[0]}, 8'h01);
      cmp({7'h0, irq}, 8'h01);
      bus(1'b1, `FTM_ADR_IEN, 8'h00);
      cmp({7'h0, irq}, 8'h00);
      // Count equal to the limit is no failure
      bus(1'b1, `FTM_ADR_LIM1, 8'hFF);
      wdone(2);
      bus(1'b1, `FTM_ADR_ICLR, 8'h01);
      wdone(2);
      bus(1'b0, `FTM_ADR_STAT, 8'h00);
      cmp({7'h0, q[0]}, 8'h00);
      // Reset in mid-run brings pin select and divisors back
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(`FTM_ADR_CHMODE, 8'h00);
      rc(`FTM_ADR_FANDIV, {4'h5, vid});
      rc(`FTM_ADR_VAL1, 8'h00);
      cmp({7'h0, irq}, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
